//--- hdl/pspc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - One to three coils form the cell
// - Selected coils must all overlap each other
// - Matching switch open for one coil only
// - Switching frequency stays within 105 to 113 kHz
// - Power set by phase between bridge halves
// - Phase 0 to 180 degrees, larger means less
// - Phase step 0.42 degrees or finer
// - Ping starts at 120 degrees phase
// - Control loop output drives the phase
// - Cell current measured to 5 mA or finer
// - Cap current 4 A or 2 A RMS
// - Gain 1, no I or D, cap 2000
module pspc_ctrl
  import pspc_pkg::*;
#(
  parameter int NUM_COILS = 8, // Coils behind the multiplexer
  parameter int OVL_SPAN = 2, // Coils overlap when index distance is at most this
  parameter int LOOP_GAIN = PROP_GAIN // Proportional gain
) (
  input wire logic aclk, // System clock, 40 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [15:0] cur_amp_ma, // Cell current amplitude, 1 mA per count
  input wire logic cur_valid, // One-cycle strobe for a new sample
  output logic [NUM_COILS-1:0] coil_sel, // Multiplexer coil enables
  output logic match_sw, // Matching-network switch, high closes it
  output logic bridge_a_hi, // First half, high side
  output logic bridge_a_lo, // First half, low side
  output logic bridge_b_hi, // Second half, high side
  output logic bridge_b_lo // Second half, low side
);

  typedef enum logic {ST_IDLE, ST_DRIVE} pspc_state_t;

  // Bus-side registers
  logic aw_have_q; // Write address held
  logic [7:0] aw_addr_q; // Held write address
  logic w_have_q; // Write data held
  logic [31:0] w_data_q; // Held write data
  logic [3:0] w_strb_q; // Held strobes
  logic bvalid_q; // Write answer pending
  logic [1:0] bresp_q; // Write answer code
  logic rvalid_q; // Read answer pending
  logic [31:0] rdata_q; // Read answer data
  logic [1:0] rresp_q; // Read answer code

  // Software-visible control
  logic run_q; // Run request
  logic [NUM_COILS-1:0] coil_pend_q; // Selection to apply at next start
  logic [ACC_W-1:0] step_q; // Requested frequency step
  logic [15:0] setp_q; // Current setpoint, mA

  // Drive state
  pspc_state_t state_q; // Stopped or driving
  logic [NUM_COILS-1:0] coil_act_q; // Selection on the multiplexer
  logic match_q; // Matching switch state
  logic [ACC_W-1:0] step_act_q; // Frequency step in use
  logic [ACC_W-1:0] acc_q; // Shared phase accumulator
  logic [PHASE_W-1:0] phase_q; // Phase offset, 0.01 degree units
  logic [15:0] cur_q; // Last current sample
  logic limit_q; // Last sample was taken while driving and was over the cap

  // Selection checks on the pending mask
  // A net, since every bit has its own continuous assignment
  wire logic [NUM_COILS*NUM_COILS-1:0] bad_pair; // Selected pairs that do not overlap
  wire logic [7:0] pend_cnt = 8'($countones(coil_pend_q));
  wire logic sel_ok = (pend_cnt >= 8'd1) && (pend_cnt <= 8'(MAX_CELL))
                      && (bad_pair == '0);

  // Pairwise overlap table, fixed by geometry
  for (genvar i = 0; i < NUM_COILS; i++) begin : g_row
    for (genvar j = 0; j < NUM_COILS; j++) begin : g_col
      if (j > i && (j - i) > OVL_SPAN) begin : g_far
        assign bad_pair[i*NUM_COILS+j] = coil_pend_q[i] & coil_pend_q[j];
      end else begin : g_near
        assign bad_pair[i*NUM_COILS+j] = 1'b0;
      end
    end
  end

  // Frequency request held inside the band
  wire logic [ACC_W-1:0] step_clamp = (step_q < STEP_MIN) ? STEP_MIN :
                                      (step_q > STEP_MAX) ? STEP_MAX : step_q;

  wire logic running = (state_q == ST_DRIVE);
  wire logic start = (state_q == ST_IDLE) && run_q && sel_ok;
  wire logic stop = running && !run_q;

  // Read mux shared by the read channel and write merging
  function automatic logic [31:0] reg_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      ADDR_CTRL: v[CTRL_RUN_BIT] = run_q;
      ADDR_COIL: v[NUM_COILS-1:0] = coil_pend_q;
      ADDR_FREQ: v[ACC_W-1:0] = step_q;
      ADDR_SETP: v[15:0] = setp_q;
      ADDR_STAT: begin
        v[STAT_RUN_BIT] = running;
        v[STAT_OK_BIT] = sel_ok;
        v[STAT_LIM_BIT] = limit_q;
        v[STAT_MSW_BIT] = match_q;
      end
      ADDR_PHASE: v[PHASE_W-1:0] = phase_q;
      ADDR_CURR: v[15:0] = cur_q;
      ADDR_ACT: v[NUM_COILS-1:0] = coil_act_q;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= ADDR_ACT);
  endfunction

  // Write decode and byte-lane merge
  wire logic do_write = aw_have_q && w_have_q && !bvalid_q;
  wire logic [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                             {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire logic [31:0] wr_word = (reg_word(aw_addr_q) & ~wmask) | (w_data_q & wmask);
  wire logic wr_ctrl = do_write && (aw_addr_q == ADDR_CTRL);
  wire logic wr_coil = do_write && (aw_addr_q == ADDR_COIL);
  wire logic wr_freq = do_write && (aw_addr_q == ADDR_FREQ);
  wire logic wr_setp = do_write && (aw_addr_q == ADDR_SETP);
  wire logic take_ar = s_axi_arvalid && !rvalid_q;

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Write address and data are caught independently, in any order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write answer; read-only and unmapped words give SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_ctrl || wr_coil || wr_freq || wr_setp) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (take_ar) begin
      rvalid_q <= 1'b1;
      rdata_q <= reg_word(s_axi_araddr);
      rresp_q <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Software registers; a pending mask may be rewritten while driving
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
      coil_pend_q <= '0;
      step_q <= STEP_RST;
      setp_q <= SETP_RST;
    end else begin
      if (wr_ctrl) run_q <= wr_word[CTRL_RUN_BIT];
      if (wr_coil) coil_pend_q <= wr_word[NUM_COILS-1:0];
      if (wr_freq) step_q <= wr_word[ACC_W-1:0];
      if (wr_setp) setp_q <= wr_word[15:0];
    end
  end

  // Control loop: proportional term only, since I and D gains are zero
  wire logic signed [17:0] err = $signed({2'b00, setp_q}) - $signed({2'b00, cur_amp_ma});
  wire logic signed [31:0] pid_raw = 32'(err) * LOOP_GAIN;
  wire logic signed [31:0] pid_cap =
    (pid_raw > LOOP_OUT_CAP) ? 32'(LOOP_OUT_CAP) :
    (pid_raw < -LOOP_OUT_CAP) ? -32'(LOOP_OUT_CAP) : pid_raw;
  // Cap is picked from the cell size; amplitude input compared to RMS times sqrt 2
  wire logic [15:0] lim_pk = match_q ? LIM_MULTI_PK : LIM_SINGLE_PK;
  wire logic over_lim = cur_amp_ma > lim_pk;
  // Over the cap the phase backs off by the full step regardless of the loop
  wire logic signed [31:0] phase_try = over_lim ?
    (32'(phase_q) + LOOP_OUT_CAP) : (32'(phase_q) - pid_cap);
  wire logic [PHASE_W-1:0] phase_next =
    (phase_try < 0) ? '0 :
    (phase_try > 32'(PHASE_MAX)) ? PHASE_MAX : phase_try[PHASE_W-1:0];

  // Phase to accumulator counts, 0.01 degree resolution kept in the product
  wire logic [63:0] off_wide = 64'(phase_q) * 64'(PHASE_K);
  wire logic [ACC_W-1:0] phase_off = off_wide[ACC_W+PHASE_FRAC-1:PHASE_FRAC];

  // Drive state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start) state_q <= ST_DRIVE;
        ST_DRIVE: if (stop) state_q <= ST_IDLE;
      endcase
    end
  end

  // Cell selection latched only at start, while the gates are still off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coil_act_q <= '0;
      match_q <= 1'b0;
      step_act_q <= STEP_RST;
    end else if (start) begin
      coil_act_q <= coil_pend_q;
      match_q <= (pend_cnt > 8'd1);
      step_act_q <= step_clamp;
    end
  end

  // Accumulator runs only while driving so each burst starts at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= '0;
    end else if (running) begin
      acc_q <= acc_q + step_act_q;
    end else begin
      acc_q <= '0;
    end
  end

  // Phase and current sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= PHASE_PING;
      cur_q <= 16'h0000;
      limit_q <= 1'b0;
    end else begin
      if (start) begin
        phase_q <= PHASE_PING;
      end else if (running && cur_valid) begin
        phase_q <= phase_next;
      end
      if (cur_valid) begin
        cur_q <= cur_amp_ma;
        limit_q <= running && over_lim;
      end
    end
  end

  assign coil_sel = coil_act_q;
  assign match_sw = match_q;

  // Two halves, the second delayed by the commanded phase
  pspc_half_bridge #(.W(ACC_W)) u_half_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(running),
    .acc(acc_q),
    .offset('0),
    .gate_hi(bridge_a_hi),
    .gate_lo(bridge_a_lo)
  );

  pspc_half_bridge #(.W(ACC_W)) u_half_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(running),
    .acc(acc_q),
    .offset(phase_off),
    .gate_hi(bridge_b_hi),
    .gate_lo(bridge_b_lo)
  );

  // Checks
  a_cell_size: assert property (@(posedge aclk) disable iff (!aresetn)
    running |-> ($countones(coil_sel) >= 1 && $countones(coil_sel) <= MAX_CELL))
    else $error("cell size out of range");
  a_sel_overlap: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(running) |-> $past(bad_pair) == '0)
    else $error("non-overlapping coils started");
  a_match_sw: assert property (@(posedge aclk) disable iff (!aresetn)
    running |-> (match_sw == ($countones(coil_sel) > 1)))
    else $error("matching switch wrong for cell");
  a_freq_band: assert property (@(posedge aclk) disable iff (!aresetn)
    running |-> (step_act_q >= STEP_MIN && step_act_q <= STEP_MAX))
    else $error("frequency outside band");
  a_phase_range: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_q <= PHASE_MAX)
    else $error("phase above 180 degrees");
  a_ping_phase: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(running) |-> phase_q == PHASE_PING)
    else $error("ping phase not 120 degrees");
  a_loop_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (running && cur_valid && !over_lim && !stop) |=>
      (int'(phase_q) >= int'($past(phase_q)) - LOOP_OUT_CAP) &&
      (int'(phase_q) <= int'($past(phase_q)) + LOOP_OUT_CAP))
    else $error("loop step above cap");
  a_cur_cap: assert property (@(posedge aclk) disable iff (!aresetn)
    (running && cur_valid && over_lim) |=> phase_q >= $past(phase_q))
    else $error("phase lowered while over current cap");
  a_gate_comp: assert property (@(posedge aclk) disable iff (!aresetn)
    (running && $past(running)) |-> (bridge_a_hi != bridge_a_lo) && (bridge_b_hi != bridge_b_lo))
    else $error("bridge gates not complementary");
  a_quiet_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    ((running && $past(running)) || bridge_a_hi || bridge_a_lo) |->
      $stable(coil_sel) && $stable(match_sw))
    else $error("coil selection changed while driving");

endmodule // pspc_ctrl

`default_nettype wire

//--- hdl/pspc_pkg.sv
package pspc_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] ADDR_CTRL = 8'h00; // Run request
  localparam logic [7:0] ADDR_COIL = 8'h04; // Pending coil mask
  localparam logic [7:0] ADDR_FREQ = 8'h08; // Switching frequency step
  localparam logic [7:0] ADDR_SETP = 8'h0C; // Current setpoint, mA
  localparam logic [7:0] ADDR_STAT = 8'h10; // Status, read only
  localparam logic [7:0] ADDR_PHASE = 8'h14; // Active phase, read only
  localparam logic [7:0] ADDR_CURR = 8'h18; // Last current sample, read only
  localparam logic [7:0] ADDR_ACT = 8'h1C; // Active coil mask, read only

  // Field positions
  localparam int CTRL_RUN_BIT = 0; // Run request in control
  localparam int STAT_RUN_BIT = 0; // Drive running
  localparam int STAT_OK_BIT = 1; // Pending selection legal
  localparam int STAT_LIM_BIT = 2; // Current cap active
  localparam int STAT_MSW_BIT = 3; // Matching switch closed

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Clock and frequency band, in Hz
  localparam longint CLK_HZ = 40_000_000;
  localparam longint FREQ_MIN_HZ = 105_000;
  localparam longint FREQ_MAX_HZ = 113_000;
  localparam longint FREQ_RST_HZ = 109_000;
  localparam int ACC_W = 24; // Phase accumulator width
  // Least step rounds up, largest rounds down, so the band is never left
  localparam logic [ACC_W-1:0] STEP_MIN =
    ACC_W'(((FREQ_MIN_HZ << ACC_W) + CLK_HZ - 1) / CLK_HZ);
  localparam logic [ACC_W-1:0] STEP_MAX = ACC_W'((FREQ_MAX_HZ << ACC_W) / CLK_HZ);
  localparam logic [ACC_W-1:0] STEP_RST = ACC_W'((FREQ_RST_HZ << ACC_W) / CLK_HZ);

  // Phase in units of 0.01 degree
  localparam int PHASE_W = 15;
  localparam logic [PHASE_W-1:0] PHASE_MAX = 15'd18000; // 180 degrees
  localparam logic [PHASE_W-1:0] PHASE_PING = 15'd12000; // 120 degrees
  localparam int PHASE_FRAC = 10; // Extra bits in the phase-to-accumulator scale
  // Accumulator counts per 0.01 degree, scaled by 2^PHASE_FRAC
  localparam longint PHASE_K = (64'd1 << (ACC_W + PHASE_FRAC)) / 36000;

  // Loop constants
  localparam int PROP_GAIN = 1; // Per mA
  localparam int LOOP_OUT_CAP = 2000; // Output cap, in phase units
  localparam logic [15:0] SETP_RST = 16'h03E8; // 1000 mA after reset

  // RMS caps in mA, turned into peak figures for the amplitude input
  localparam longint LIM_MULTI_MA = 4000;
  localparam longint LIM_SINGLE_MA = 2000;
  localparam logic [15:0] LIM_MULTI_PK = 16'((LIM_MULTI_MA * 14142) / 10000);
  localparam logic [15:0] LIM_SINGLE_PK = 16'((LIM_SINGLE_MA * 14142) / 10000);

  localparam int MAX_CELL = 3; // Coils in one cell at most

endpackage

//--- hdl/pspc_half_bridge.sv
`timescale 1ns/1ps
`default_nettype none

// One bridge half: complementary gates from the shared accumulator
module pspc_half_bridge
  import pspc_pkg::*;
#(
  parameter int W = ACC_W // Accumulator width
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic enable, // Drive allowed
  input wire logic [W-1:0] acc, // Shared phase accumulator
  input wire logic [W-1:0] offset, // Delay of this half, in accumulator counts
  output logic gate_hi, // High-side gate
  output logic gate_lo // Low-side gate
);

  // Subtracting the offset delays this half against the accumulator
  wire logic [W-1:0] pos = acc - offset;
  wire logic half_sel = pos[W-1];

  // Registered gates; both off when disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_hi <= 1'b0;
      gate_lo <= 1'b0;
    end else begin
      gate_hi <= enable & ~half_sel;
      gate_lo <= enable & half_sel;
    end
  end

endmodule // pspc_half_bridge

`default_nettype wire

//--- tb/pspc_stage_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the power stage: current sensor plus gate timing probe
module pspc_stage_model (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic a_hi, // First half, high side
  input wire logic a_lo, // First half, low side
  input wire logic b_hi, // Second half, high side
  input wire logic b_lo, // Second half, low side
  input wire logic go, // Bench asks for one sample
  input wire logic [15:0] amp, // Amplitude to report, mA
  output logic [15:0] cur_amp_ma, // Sensor amplitude
  output logic cur_valid, // Sample strobe
  output logic [15:0] period, // Cycles between first-half rises
  output logic [15:0] hi_len, // High cycles of first half
  output logic [15:0] lag, // Cycles from first-half rise to second-half rise
  output logic [15:0] rises, // First-half rises seen
  output logic [15:0] bad // Cycles with a pair not complementary
);
  logic a_q; // Previous first-half level
  logic b_q; // Previous second-half level
  logic [15:0] cnt_q; // Cycles since first-half rise
  logic [15:0] hc_q; // High cycles so far
  wire logic a_rise = a_hi && !a_q; // First half rises
  wire logic b_rise = b_hi && !b_q; // Second half rises

  // Sensor: real sample on request, else a line that keeps moving
  always_ff @(posedge aclk) begin
    cur_valid <= go && aresetn;
    cur_amp_ma <= go ? amp : ~cur_amp_ma;
  end

  // Probe: period, duty, lag and pairing of the gates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      cnt_q <= 16'h0000;
      hc_q <= 16'h0000;
      rises <= 16'h0000;
      bad <= 16'h0000;
    end else begin
      a_q <= a_hi;
      b_q <= b_hi;
      cnt_q <= a_rise ? 16'h0001 : cnt_q + 16'h0001;
      hc_q <= a_rise ? 16'h0001 : hc_q + 16'(a_hi);
      if (a_rise) begin
        period <= cnt_q;
        hi_len <= hc_q;
        rises <= rises + 16'h0001;
      end
      // Same-cycle rise means halves in phase
      if (b_rise) begin
        lag <= a_rise ? 16'h0000 : cnt_q;
      end
      // Only judged while driving; idle has all gates low
      if ((a_hi || a_lo) && (a_hi == a_lo || b_hi == b_lo)) begin
        bad <= bad + 16'h0001;
      end
    end
  end
endmodule // pspc_stage_model

`default_nettype wire

//--- tb/phase_shift_power_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

module phase_shift_power_control_tb_top
  import pspc_pkg::*;
;
  logic aclk = 1'b0; // 40 MHz clock
  logic aresetn = 1'b0; // Reset, active low
  logic [7:0] awaddr = 8'h00, araddr = 8'h00; // Addresses
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000; // Write data
  logic awready, wready, bvalid, arready, rvalid, msw, ahi, alo, bhi, blo, cvalid;
  logic go = 1'b0; // Sample request
  logic [1:0] bresp, rresp; // Responses
  logic [31:0] rdata; // Read data
  logic [15:0] amp = 16'h0000, camp, period, hi_len, lag, rises, bad;
  logic [7:0] coil; // Coil enables
  int n_fail = 0, check_count = 0, ph = 12000, setp = 1000; // Counters, expected loop state
  logic multi = 1'b0; // Expected cell has two or three coils

  always #12.5 aclk = ~aclk;

  pspc_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cur_amp_ma(camp), .cur_valid(cvalid), .coil_sel(coil), .match_sw(msw),
    .bridge_a_hi(ahi), .bridge_a_lo(alo), .bridge_b_hi(bhi), .bridge_b_lo(blo));

  pspc_stage_model u_stage (.aclk(aclk), .aresetn(aresetn), .a_hi(ahi), .a_lo(alo),
    .b_hi(bhi), .b_lo(blo), .go(go), .amp(amp), .cur_amp_ma(camp), .cur_valid(cvalid),
    .period(period), .hi_len(hi_len), .lag(lag), .rises(rises), .bad(bad));

  // Verdict and end of run
  task automatic conclude();
    $display("TB: checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bound on every wait
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 3000) begin
      n_fail++;
      $display("[ERR] wait expected answer seen none");
      conclude();
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w) begin
      tick(n);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do tick(n); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  // Read one word, then compare under a mask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do tick(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1; // Raised a cycle after the address, never twice in one step
    do tick(n); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK($sformatf("reg %h", a), e, rdata & m)
    `CHK("rresp", (a > ADDR_ACT) ? RESP_SLVERR : RESP_OKAY, rresp)
  endtask

  // One current sample; expected phase from the loop and cap figures
  task automatic smp(input int c);
    int cap;
    int err;
    cap = multi ? int'(LIM_MULTI_PK) : int'(LIM_SINGLE_PK);
    err = PROP_GAIN * (setp - c);
    err = err > LOOP_OUT_CAP ? LOOP_OUT_CAP : err < -LOOP_OUT_CAP ? -LOOP_OUT_CAP : err;
    ph = (c > cap) ? ph + LOOP_OUT_CAP : ph - err;
    ph = ph < 0 ? 0 : ph > int'(PHASE_MAX) ? int'(PHASE_MAX) : ph;
    amp <= 16'(c);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    rc(ADDR_PHASE, 32'(ph), 32'hFFFF_FFFF);
    rc(ADDR_CURR, 32'(c), 32'hFFFF_FFFF);
    rc(ADDR_STAT, 32'(c > cap) << 2, 32'h0000_0004);
  endtask

  // Gate timing after three fresh first-half rises
  task automatic meas(input int step);
    int lo;
    int r0;
    int n;
    lo = (1 << 24) / step;
    r0 = rises;
    n = 0;
    while (rises < r0 + 3) tick(n);
    `CHK("period", 1'b1, period >= lo && period <= lo + 1)
    `CHK("duty", 1'b1, hi_len + 1 >= lo / 2 && hi_len <= lo / 2 + 1)
    `CHK("lag", 1'b1, lag + 3 >= ph * lo / 36000 && lag <= ph * lo / 36000 + 3)
    `CHK("pairs", 16'h0000, bad)
  endtask

  // Main sequence
  initial begin
    logic [7:0] mk [7];
    logic ok [7];
    mk = '{8'h00, 8'h0F, 8'h09, 8'h81, 8'h05, 8'h07, 8'hC0};
    ok = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rc(ADDR_FREQ, 32'(STEP_RST), 32'hFFFF_FFFF);
    rc(ADDR_SETP, 32'h0000_03E8, 32'hFFFF_FFFF);
    rc(ADDR_PHASE, 32'd12000, 32'hFFFF_FFFF);
    rc(ADDR_ACT, 32'h0000_0000, 32'hFFFF_FFFF);
    rc(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    axw(ADDR_PHASE, 32'h0000_0000, RESP_SLVERR);
    axw(8'h02, 32'h0000_0001, RESP_SLVERR);
    `CHK("gates", 4'h0, {ahi, alo, bhi, blo})
    $display("test reset done");
    // Cell legality table: count and mutual overlap
    for (int i = 0; i < 7; i++) begin
      axw(ADDR_COIL, 32'(mk[i]), RESP_OKAY);
      rc(ADDR_STAT, 32'(ok[i]) << 1, 32'h0000_0002);
    end
    axw(ADDR_COIL, 32'h0000_0009, RESP_OKAY);
    axw(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    repeat (4) @(posedge aclk);
    rc(ADDR_STAT, 32'h0000_0000, 32'h0000_0001);
    `CHK("coil_sel", 8'h00, coil)
    $display("test legality done");
    // Run still requested, so a legal mask starts at once
    axw(ADDR_COIL, 32'h0000_0001, RESP_OKAY);
    rc(ADDR_STAT, 32'h0000_0001, 32'h0000_0009);
    `CHK("coil_sel", 8'h01, coil)
    `CHK("match_sw", 1'b0, msw)
    rc(ADDR_PHASE, 32'd12000, 32'hFFFF_FFFF);
    meas(STEP_RST);
    axw(ADDR_COIL, 32'h0000_0006, RESP_OKAY);
    repeat (4) @(posedge aclk);
    `CHK("coil_sel", 8'h01, coil)
    rc(ADDR_ACT, 32'h0000_0001, 32'hFFFF_FFFF);
    $display("test single done");
    smp(1001);
    smp(1500);
    smp(2700);
    smp(2829);
    smp(2828);
    meas(STEP_RST);
    axw(ADDR_SETP, 32'd5000, RESP_OKAY);
    setp = 5000;
    repeat (9) smp(0);
    meas(STEP_RST);
    $display("test loop done");
    // Stop, then restart with the waiting two-coil mask above the band
    axw(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK("gates", 4'h0, {ahi, alo, bhi, blo})
    `CHK("coil_sel", 8'h01, coil)
    axw(ADDR_FREQ, 32'd60000, RESP_OKAY);
    axw(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    // Start lands on the edge that ends the write; look once it has settled
    @(posedge aclk);
    `CHK("coil_sel", 8'h06, coil)
    `CHK("match_sw", 1'b1, msw)
    rc(ADDR_STAT, 32'h0000_0009, 32'h0000_0009);
    multi = 1'b1;
    ph = 12000;
    rc(ADDR_PHASE, 32'd12000, 32'hFFFF_FFFF);
    meas(STEP_MAX);
    smp(5656);
    smp(5657);
    $display("test multi done");
    axw(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    repeat (3) @(posedge aclk);
    axw(ADDR_FREQ, 32'd100, RESP_OKAY);
    axw(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    ph = 12000;
    meas(STEP_MIN);
    $display("test band done");
    conclude();
  end
endmodule // phase_shift_power_control_tb_top

`default_nettype wire
